// >>> pkg/gwr_pkg.sv
// Purpose: Types of the bus interface write register block
// Assumes: Nothing
// Notes:   Constants live in gwr_regs.svh
package gwr_pkg;
   typedef enum logic [1:0] {
      GWR_IFC_IDLE,
      GWR_IFC_HOLD,
      GWR_IFC_DONE
   } gwr_ifc_st_t;
endpackage

// >>> pkg/gwr_regs.svh
// Purpose: Offsets, field positions and timing counts of the bus interface write registers
// Assumes: 10 MHz core clock
// Notes:   Offsets are register numbers on the host write port
`ifndef GWR_REGS_SVH
`define GWR_REGS_SVH
`define GWR_OFF_RESET      5'h00
`define GWR_OFF_IRQ_EN     5'h03
`define GWR_OFF_HOLDOFF    5'h04
`define GWR_OFF_MASK_HI    5'h11
`define GWR_OFF_MASK_LO    5'h13
`define GWR_OFF_AUX        5'h17
`define GWR_OFF_ADDR       5'h19
`define GWR_OFF_SPOLL      5'h1b
`define GWR_OFF_PPOLL      5'h1d
`define GWR_OFF_DOUT       5'h1f
`define GWR_IRQ_EN_BIT     7
`define GWR_AUX_SET_BIT    7
`define GWR_AUX_FN_MSB     4
`define GWR_MASK_HI_W      6
`define GWR_FN_GET_PULSE   5'h05
`define GWR_FN_GET_LEVEL   5'h06
`define GWR_FN_IFC         5'h0f
`define GWR_FN_REN         5'h10
`define GWR_FN_IRQ_ALL     5'h13
`define GWR_FN_CHIP_RESET  5'h00
`define GWR_CLK_KHZ        10000
`define GWR_IFC_HOLD_US    101
`define GWR_IFC_CYCLES     ((`GWR_IFC_HOLD_US * `GWR_CLK_KHZ + 999) / 1000)
`define GWR_IFC_CNT_W      11
`endif

// >>> rtl/gwr_ifc_timer.sv
// Purpose: Holds interface clear asserted for a minimum time
// Assumes: One-cycle start and stop requests
// Notes:   Stop is honoured only after the minimum time has run
`include "gwr_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module gwr_ifc_timer (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic start,
   input  wire logic stop,
   input  wire logic abort,
   output logic      ifc_out
);
   typedef struct packed {
      gwr_pkg::gwr_ifc_st_t            st;
      logic [`GWR_IFC_CNT_W-1:0]       cnt;
      logic                            stop_pend;
   } gwr_tmr_t;
   gwr_tmr_t s_q;
   gwr_tmr_t s_d;

   always_comb begin
      s_d = s_q;
      case (s_q.st)
         gwr_pkg::GWR_IFC_IDLE: begin
            if (start) begin
               s_d.st = gwr_pkg::GWR_IFC_HOLD;
               s_d.cnt = `GWR_IFC_CNT_W'(`GWR_IFC_CYCLES);
               s_d.stop_pend = 1'b0;
            end
         end
         gwr_pkg::GWR_IFC_HOLD: begin
            if (stop) begin
               s_d.stop_pend = 1'b1;
            end
            if (s_q.cnt <= `GWR_IFC_CNT_W'(1)) begin
               s_d.st = gwr_pkg::GWR_IFC_DONE;
            end else begin
               s_d.cnt = s_q.cnt - `GWR_IFC_CNT_W'(1);
            end
         end
         gwr_pkg::GWR_IFC_DONE: begin
            if (stop || s_q.stop_pend) begin
               s_d.st = gwr_pkg::GWR_IFC_IDLE;
               s_d.stop_pend = 1'b0;
            end
         end
         default: s_d.st = gwr_pkg::GWR_IFC_IDLE;
      endcase
      if (abort) begin
         s_d = '0;
         s_d.st = gwr_pkg::GWR_IFC_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign ifc_out = (s_q.st != gwr_pkg::GWR_IFC_IDLE);
endmodule // gwr_ifc_timer
`default_nettype wire

// >>> rtl/gwr_trig_sel.sv
// Purpose: Picks which bus devices a trigger reaches
// Assumes: Listen map is one bit per primary address
// Notes:   Registered output, one cycle after the request
`timescale 1ns/100ps
`default_nettype none
module gwr_trig_sel (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        trig_req,
   input  wire logic        trig_addressed,
   input  wire logic [4:0]  trig_addr,
   input  wire logic [30:0] listen_map,
   output logic      [30:0] trig_out
);
   typedef struct packed {
      logic [30:0] hit;
   } gwr_trg_t;
   gwr_trg_t s_q;
   gwr_trg_t s_d;

   always_comb begin
      s_d.hit = '0;
      if (trig_req) begin
         if (trig_addressed) begin
            if (trig_addr != 5'h1f) begin
               s_d.hit[trig_addr] = 1'b1;
            end
         end else begin
            s_d.hit = listen_map;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign trig_out = s_q.hit;
endmodule // gwr_trig_sel
`default_nettype wire

// >>> rtl/gwr_write_regs.sv
// Purpose: Write-side register file of the bus interface controller
// Assumes: Host write strobe synchronous to clk, register number and data valid with it
// Notes:   All registers are write only; state is shown on plain output ports
`include "gwr_regs.svh"
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Write-only registers at numbers 0,3,4,17,19,23,25,27,29,31.
// - Any write to register 0 resets the whole bus interface.
// - Byte access writes eight bits; word access writes a full word to register 31, register 4 tests all 16 bits for zero, other registers keep eight bits.
// - Interrupt enable bit 7 and the clear form of function 19 together enable interface interrupts globally.
// - Any write to holdoff release frees the NDAC holdoff.
// - Nonzero release accepts last secondary address; zero rejects it.
// - Upper mask bits 5..0: byte, ready, end, SPAS, remote/local, address change.
// - Lower mask bits 7..0: trigger, handshake, unknown group, secondary, clear, address, SRQ, IFC.
// - A set mask bit lets its condition interrupt; clear bit suppresses it.
// - Auxiliary bit 7 picks set form when one, clear form when zero.
// - Auxiliary bits 4..0 pick the function; bits 6 and 5 ignored.
// - Plain trigger hits all listeners; addressed trigger hits one device.
// - Set form of function 15 holds interface clear over 100 microseconds.
module gwr_write_regs (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        sys_ctrl,
   input  wire logic        wr_stb,
   input  wire logic        wr_word,
   input  wire logic [4:0]  wr_reg,
   input  wire logic [15:0] wr_data,
   input  wire logic [7:0]  cond_lo,
   input  wire logic [5:0]  cond_hi,
   input  wire logic [30:0] listen_map,
   input  wire logic        trig_req,
   input  wire logic        trig_addressed,
   input  wire logic [4:0]  trig_addr,
   output logic             if_reset,
   output logic             irq_out,
   output logic             ndac_release,
   output logic             sec_accept,
   output logic             sec_reject,
   output logic             ifc_out,
   output logic             ren_out,
   output logic             get_out,
   output logic             aux_stb,
   output logic             aux_set,
   output logic [4:0]       aux_fn,
   output logic [7:0]       bus_address,
   output logic [7:0]       serial_poll_reply,
   output logic [7:0]       parallel_poll_config,
   output logic [15:0]      data_output,
   output logic             dout_stb,
   output logic [30:0]      trig_out
);
   typedef struct packed {
      logic                        rst_p;
      logic                        irq_en;
      logic                        irq_all;
      logic [`GWR_MASK_HI_W-1:0]   mask_hi;
      logic [7:0]                  mask_lo;
      logic                        irq;
      logic                        rel;
      logic                        acc;
      logic                        rej;
      logic                        ren;
      logic                        get_lvl;
      logic                        get_pls;
      logic                        a_stb;
      logic                        a_set;
      logic [4:0]                  a_fn;
      logic [7:0]                  addr;
      logic [7:0]                  spoll;
      logic [7:0]                  ppoll;
      logic [15:0]                 dout;
      logic                        d_stb;
      logic                        get_o;
   } gwr_st_t;
   gwr_st_t s_q;
   gwr_st_t s_d;

   logic wr_ok;
   logic ifc_start;
   logic ifc_stop;
   logic ifc_q;

   function automatic logic is_hit(input logic [4:0] r, input logic [4:0] off);
      is_hit = (r == off);
   endfunction

   assign wr_ok = wr_stb && sys_ctrl;

   always_comb begin
      s_d = s_q;
      s_d.rst_p = 1'b0;
      s_d.rel = 1'b0;
      s_d.acc = 1'b0;
      s_d.rej = 1'b0;
      s_d.a_stb = 1'b0;
      s_d.get_pls = 1'b0;
      s_d.d_stb = 1'b0;
      ifc_start = 1'b0;
      ifc_stop = 1'b0;
      if (wr_ok) begin
         if (is_hit(wr_reg, `GWR_OFF_RESET)) begin
            s_d.rst_p = 1'b1;
         end
         if (is_hit(wr_reg, `GWR_OFF_IRQ_EN)) begin
            s_d.irq_en = wr_data[`GWR_IRQ_EN_BIT];
         end
         if (is_hit(wr_reg, `GWR_OFF_HOLDOFF)) begin
            s_d.rel = 1'b1;
            s_d.acc = (wr_word ? wr_data : {8'h00, wr_data[7:0]}) != 16'h0000;
            s_d.rej = (wr_word ? wr_data : {8'h00, wr_data[7:0]}) == 16'h0000;
         end
         if (is_hit(wr_reg, `GWR_OFF_MASK_HI)) begin
            // upper mask, bits 7 and 6 dropped
            s_d.mask_hi = wr_data[`GWR_MASK_HI_W-1:0];
         end
         if (is_hit(wr_reg, `GWR_OFF_MASK_LO)) begin
            s_d.mask_lo = wr_data[7:0];
         end
         if (is_hit(wr_reg, `GWR_OFF_AUX)) begin
            s_d.a_set = wr_data[`GWR_AUX_SET_BIT];
            // function select, bits 6 and 5 ignored
            s_d.a_fn = wr_data[`GWR_AUX_FN_MSB:0];
            s_d.a_stb = 1'b1;
            case (wr_data[`GWR_AUX_FN_MSB:0])
               `GWR_FN_IFC: begin
                  ifc_start = wr_data[`GWR_AUX_SET_BIT];
                  ifc_stop = !wr_data[`GWR_AUX_SET_BIT];
               end
               `GWR_FN_REN: s_d.ren = wr_data[`GWR_AUX_SET_BIT];
               `GWR_FN_GET_PULSE: begin
                  if (wr_data[`GWR_AUX_SET_BIT]) begin
                     s_d.get_pls = !s_q.get_lvl;
                     s_d.get_lvl = 1'b0;
                  end
               end
               `GWR_FN_GET_LEVEL: begin
                  if (wr_data[`GWR_AUX_SET_BIT]) begin
                     s_d.get_lvl = 1'b1;
                  end
               end
               `GWR_FN_IRQ_ALL: s_d.irq_all = !wr_data[`GWR_AUX_SET_BIT];
               default: begin
               end
            endcase
         end
         if (is_hit(wr_reg, `GWR_OFF_ADDR)) begin
            s_d.addr = wr_data[7:0];
         end
         if (is_hit(wr_reg, `GWR_OFF_SPOLL)) begin
            s_d.spoll = wr_data[7:0];
         end
         if (is_hit(wr_reg, `GWR_OFF_PPOLL)) begin
            s_d.ppoll = wr_data[7:0];
         end
         if (is_hit(wr_reg, `GWR_OFF_DOUT)) begin
            s_d.dout = wr_word ? wr_data : {8'h00, wr_data[7:0]};
            s_d.d_stb = 1'b1;
         end
      end
      s_d.irq = s_q.irq_en && s_q.irq_all &&
                (|(cond_lo & s_q.mask_lo) || |(cond_hi & s_q.mask_hi));
      s_d.get_o = s_d.get_lvl || s_d.get_pls;
      if (s_q.rst_p) begin
         s_d = '0;
         s_d.irq_all = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.irq_all <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ifc_out <= 1'b0;
      end else begin
         ifc_out <= ifc_q;
      end
   end

   gwr_ifc_timer u_ifc (
      .clk     (clk),
      .rst_n   (rst_n),
      .start   (ifc_start),
      .stop    (ifc_stop),
      .abort   (s_q.rst_p),
      .ifc_out (ifc_q)
   );

   gwr_trig_sel u_trig (
      .clk            (clk),
      .rst_n          (rst_n),
      .trig_req       (trig_req || s_q.get_pls),
      .trig_addressed (trig_addressed && !s_q.get_pls),
      .trig_addr      (trig_addr),
      .listen_map     (listen_map),
      .trig_out       (trig_out)
   );

   assign if_reset             = s_q.rst_p;
   assign irq_out              = s_q.irq;
   assign ndac_release         = s_q.rel;
   assign sec_accept           = s_q.acc;
   assign sec_reject           = s_q.rej;
   assign ren_out              = s_q.ren;
   assign get_out              = s_q.get_o;
   assign aux_stb              = s_q.a_stb;
   assign aux_set              = s_q.a_set;
   assign aux_fn               = s_q.a_fn;
   assign bus_address          = s_q.addr;
   assign serial_poll_reply    = s_q.spoll;
   assign parallel_poll_config = s_q.ppoll;
   assign data_output          = s_q.dout;
   assign dout_stb             = s_q.d_stb;
endmodule // gwr_write_regs
`default_nettype wire

// >>> test/gwr_bus_dev.sv
// Purpose: Bus instruments that may act on a trigger
// Assumes: One bit per primary address
// Notes:   Registered, one cycle after the trigger lines
`timescale 1ns/100ps
`default_nettype none
module gwr_bus_dev (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [30:0] listen_map,
   input  wire logic [30:0] src_bus,
   input  wire logic [30:0] waiting,
   input  wire logic [30:0] trig_out,
   output logic      [30:0] acted_q
);
   always_ff @(posedge clk) begin
      if (!rst_n) acted_q <= 31'h00000000;
      else acted_q <= trig_out & src_bus & waiting & listen_map;
   end
endmodule // gwr_bus_dev
`default_nettype wire

// >>> test/gwr_write_regs_chk.sv
// Purpose: Port checks of the write register block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to the top module
`timescale 1ns/100ps
`default_nettype none
module gwr_write_regs_chk (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        sys_ctrl,
   input wire logic        wr_stb,
   input wire logic        wr_word,
   input wire logic [4:0]  wr_reg,
   input wire logic [15:0] wr_data,
   input wire logic [7:0]  cond_lo,
   input wire logic [5:0]  cond_hi,
   input wire logic [30:0] listen_map,
   input wire logic        trig_req,
   input wire logic        trig_addressed,
   input wire logic [4:0]  trig_addr,
   input wire logic        if_reset,
   input wire logic        irq_out,
   input wire logic        ndac_release,
   input wire logic        sec_accept,
   input wire logic        sec_reject,
   input wire logic        ifc_out,
   input wire logic        aux_stb,
   input wire logic        aux_set,
   input wire logic [4:0]  aux_fn,
   input wire logic [15:0] data_output,
   input wire logic [30:0] trig_out
);
   logic        wen;
   logic        nz;
   logic [10:0] hi_q;
   assign wen = wr_stb && sys_ctrl;
   assign nz  = wr_word ? (wr_data != 16'h0000) : (wr_data[7:0] != 8'h00);
   // Cycles spent with interface clear high
   always_ff @(posedge clk) begin
      if (!rst_n || !ifc_out) hi_q <= 11'h000;
      else if (hi_q != 11'h7ff) hi_q <= hi_q + 11'h001;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_reset_pulse: assert property (wen && wr_reg == 5'h00 |=> if_reset)
      else $error("reset pulse missing");
   chk_reset_clear: assert property (if_reset |=> data_output == 16'h0000 && aux_fn == 5'h00)
      else $error("registers not cleared");
   chk_holdoff_go: assert property (wen && wr_reg == 5'h04 |=> ndac_release)
      else $error("holdoff not released");
   chk_sec_accept: assert property (wen && wr_reg == 5'h04 && nz |=> sec_accept && !sec_reject)
      else $error("secondary not accepted");
   chk_sec_reject: assert property (wen && wr_reg == 5'h04 && !nz |=> sec_reject && !sec_accept)
      else $error("secondary not rejected");
   chk_aux_fields: assert property (wen && wr_reg == 5'h17 |=> aux_stb && aux_set == $past(wr_data[7]) && aux_fn == $past(wr_data[4:0]))
      else $error("aux fields wrong");
   chk_irq_cause: assert property (irq_out |-> $past(cond_lo != 8'h00 || cond_hi != 6'h00))
      else $error("interrupt without condition");
   chk_ifc_min: assert property ($fell(ifc_out) && !$past(if_reset) && !$past(if_reset, 2) |-> hi_q > 11'd1000)
      else $error("interface clear too short");
   chk_trig_all: assert property (trig_req && !trig_addressed |=> trig_out == $past(listen_map))
      else $error("plain trigger wrong");
   chk_trig_one: assert property (trig_req && trig_addressed |=> (trig_out & ~(31'h00000001 << $past(trig_addr))) == 31'h00000000)
      else $error("addressed trigger spread");
   chk_no_ctrl: assert property (wr_stb && !sys_ctrl |=> !if_reset && !ndac_release && !aux_stb)
      else $error("write taken without control");
   cover property ($fell(ifc_out));
   cover property (sec_accept);
   cover property (trig_out != 31'h00000000 && $past(trig_addressed));
endmodule // gwr_write_regs_chk
bind gwr_write_regs gwr_write_regs_chk u_chk (.clk, .rst_n, .sys_ctrl, .wr_stb, .wr_word, .wr_reg,
   .wr_data, .cond_lo, .cond_hi, .listen_map, .trig_req, .trig_addressed, .trig_addr, .if_reset,
   .irq_out, .ndac_release, .sec_accept, .sec_reject, .ifc_out, .aux_stb, .aux_set, .aux_fn,
   .data_output, .trig_out);
`default_nettype wire

// >>> test/gwr_write_regs_tb.sv
// Purpose: Self-checking bench of the write register block
// Assumes: Inputs driven on the falling edge
// Notes:   IFC check spans about 1300 cycles
`timescale 1ns/100ps
`default_nettype none
module gwr_write_regs_tb;
   logic        clk, rst_n, sys_ctrl, wr_stb, wr_word, trig_req, trig_addressed;
   logic        if_reset, irq_out, ndac_release, sec_accept, sec_reject, ifc_out;
   logic        ren_out, get_out, aux_stb, aux_set, dout_stb;
   logic [4:0]  wr_reg, trig_addr, aux_fn;
   logic [7:0]  cond_lo, bus_address, serial_poll_reply, parallel_poll_config, m_en, m_lo, m_hi;
   logic [5:0]  cond_hi;
   logic [15:0] wr_data, data_output;
   logic [30:0] listen_map, src_bus, waiting, trig_out, acted_q, t;
   logic [16:0] ho [4];
   logic [15:0] v [4];
   int          fail_count = 0, samples_checked = 0, seed = 22, cyc = 0, n, i, j;
   gwr_write_regs u_dut (.clk, .rst_n, .sys_ctrl, .wr_stb, .wr_word, .wr_reg, .wr_data, .cond_lo,
      .cond_hi, .listen_map, .trig_req, .trig_addressed, .trig_addr, .if_reset, .irq_out,
      .ndac_release, .sec_accept, .sec_reject, .ifc_out, .ren_out, .get_out, .aux_stb, .aux_set,
      .aux_fn, .bus_address, .serial_poll_reply, .parallel_poll_config, .data_output, .dout_stb,
      .trig_out);
   gwr_bus_dev u_dev (.clk, .rst_n, .listen_map, .src_bus, .waiting, .trig_out, .acted_q);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task end_sim;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task chk_bit(input string nm, input logic e, input logic g);
      chk_val(nm, 32'(e), 32'(g));
   endtask
   task wr(input logic [4:0] r, input logic [15:0] d, input logic w);
      @(negedge clk);
      wr_stb = 1'b1;
      wr_reg = r;
      wr_data = d;
      wr_word = w;
      @(negedge clk);
      wr_stb = 1'b0;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         end_sim;
      end
   end
   initial begin
      rst_n = 1'b0;
      sys_ctrl = 1'b1;
      {wr_stb, wr_word, trig_req, trig_addressed} = 4'h0;
      {wr_reg, trig_addr, wr_data, cond_lo, cond_hi} = 40'h0;
      {listen_map, src_bus, waiting} = 93'h0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      for (j = 0; j < 2; j++) begin
         m_en = j ? 8'h80 : 8'h7f;
         m_hi = j ? 8'h24 : 8'h3f;
         m_lo = j ? 8'h81 : 8'hff;
         wr(5'h03, {8'h00, m_en}, 1'b0);
         wr(5'h11, {8'h00, m_hi}, 1'b0);
         wr(5'h13, {8'h00, m_lo}, 1'b0);
         for (i = 0; i < 40; i++) begin
            {cond_hi, cond_lo} = 14'($random(seed));
            @(negedge clk);
            chk_bit("irq_out", m_en[7] && ((cond_lo & m_lo) != 0 || ({2'b00, cond_hi} & m_hi) != 0), irq_out);
         end
      end
      $display("test irq done");
      ho = '{17'h00000, 17'h00001, 17'h10100, 17'h00100};
      foreach (ho[k]) begin
         wr(5'h04, ho[k][15:0], ho[k][16]);
         n = ho[k][16] ? int'(ho[k][15:0] != 0) : int'(ho[k][7:0] != 0);
         chk_bit("ndac_release", 1'b1, ndac_release);
         chk_bit("sec_accept", n[0], sec_accept);
         chk_bit("sec_reject", !n[0], sec_reject);
      end
      $display("test holdoff done");
      wr(5'h17, 16'h00e5, 1'b0);
      chk_val("aux", 32'h65, {25'h0, aux_stb, aux_set, aux_fn});
      chk_bit("get_out", 1'b1, get_out);
      wr(5'h17, 16'h0074, 1'b0);
      chk_val("aux", 32'h54, {25'h0, aux_stb, aux_set, aux_fn});
      wr(5'h17, 16'h0086, 1'b0);
      chk_bit("get_out", 1'b1, get_out);
      wr(5'h17, 16'h0085, 1'b0);
      chk_bit("get_out", 1'b0, get_out);
      wr(5'h17, 16'h0090, 1'b0);
      chk_bit("ren_out", 1'b1, ren_out);
      wr(5'h17, 16'h0010, 1'b0);
      chk_bit("ren_out", 1'b0, ren_out);
      cond_lo = 8'hff;
      wr(5'h17, 16'h0093, 1'b0);
      @(negedge clk);
      chk_bit("irq_all_off", 1'b0, irq_out);
      wr(5'h17, 16'h0013, 1'b0);
      @(negedge clk);
      chk_bit("irq_all_on", 1'b1, irq_out);
      cond_lo = 8'h00;
      $display("test aux done");
      for (i = 0; i < 4; i++) begin
         v[i] = 16'($random(seed));
         wr(5'h19 + 5'(2 * i), v[i], 1'b1);
      end
      chk_bit("dout_stb", 1'b1, dout_stb);
      chk_val("bus_address", 32'(v[0][7:0]), 32'(bus_address));
      chk_val("serial_poll", 32'(v[1][7:0]), 32'(serial_poll_reply));
      chk_val("parallel_poll", 32'(v[2][7:0]), 32'(parallel_poll_config));
      chk_val("data_output", 32'(v[3]), 32'(data_output));
      sys_ctrl = 1'b0;
      wr(5'h19, ~v[0], 1'b0);
      sys_ctrl = 1'b1;
      wr(5'h05, ~v[0], 1'b0);
      chk_val("bus_address", 32'(v[0][7:0]), 32'(bus_address));
      $display("test regs done");
      {listen_map, src_bus, waiting} = {31'($random(seed)), 31'($random(seed)), 31'($random(seed))};
      trig_addr = 5'($random(seed) & 15) + 5'h0a;
      listen_map[trig_addr] = 1'b1;
      for (j = 0; j < 2; j++) begin
         t = j ? 31'h00000001 << trig_addr : listen_map;
         trig_addressed = j[0];
         trig_req = 1'b1;
         @(negedge clk);
         trig_req = 1'b0;
         chk_val("trig_out", 32'(t), 32'(trig_out));
         @(negedge clk);
         chk_val("acted", 32'(t & src_bus & waiting), 32'(acted_q));
      end
      $display("test trigger done");
      wr(5'h17, 16'h008f, 1'b0);
      wr(5'h17, 16'h000f, 1'b0);
      n = 0;
      for (i = 0; i < 1300; i++) begin
         @(negedge clk);
         n += int'(ifc_out);
      end
      chk_bit("ifc_hold", 1'b1, n > 1000 && n < 1100);
      chk_bit("ifc_out", 1'b0, ifc_out);
      $display("test ifc done");
      wr(5'h00, 16'h0000, 1'b0);
      chk_bit("if_reset", 1'b1, if_reset);
      @(negedge clk);
      chk_val("regs", 32'h0, {data_output, bus_address, 3'h0, aux_fn});
      $display("test reset done");
      end_sim;
   end
endmodule // gwr_write_regs_tb
`default_nettype wire
